// ==== design/pbm_pin_mux.sv ====
// Pin mux for port B 11..13, port C and port D, with the test-port state machine.
// Assumes pins arrive unsynchronised and software configures it over AXI4-Lite.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "pbm_map.svh"

// Notes on behaviour
// - B11 carries timer B channel 1 or comparator B output; GPIO after reset.
// - C0 connects to ADC A input 0 or comparator A input 3.
// - C4 connects to ADC B input 0 or comparator B input 3.
// - C8 connects to ADC A input 4 or drives serial port 2 transmit.
// - C12 connects to ADC B input 4 or feeds serial port 2 receive.
// - D5 is crystal output or external clock input, chosen by port C/D select.
// - Power-on reset puts the test-port state machine in test-logic-reset.
// - TMS high on five consecutive TCK rises forces test-logic-reset.
// - No test-reset pin; the internal test reset stays deasserted.
module pbm_pin_mux #(
  parameter int NPIN = 27
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [31:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [31:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [NPIN-1:0]            pin_in,
  output logic [NPIN-1:0]                 pin_out,
  output logic [NPIN-1:0]                 pin_oe_n,
  input  wire logic [NPIN-1:0]            gpio_out,
  input  wire logic [NPIN-1:0]            gpio_oe,
  output logic [NPIN-1:0]                 gpio_in,
  input  wire logic                       timer_b_channel_1,
  input  wire logic                       comparator_b_output,
  input  wire logic                       can_transmit_pin,
  output logic                            can_receive_pin,
  input  wire logic                       serial2_transmit,
  output logic                            serial2_receive,
  output logic [15:0]                     adc_connect,
  output logic                            comparator_a_input_3,
  output logic                            comparator_b_input_3,
  output logic                            crystal_output,
  output logic                            external_clock_input,
  output logic                            analog_out_0,
  output logic                            analog_out_1,
  input  wire logic                       scan_tdo,
  output logic                            tap_tdi,
  output logic                            tap_tck_rise,
  output pbm_pkg::pbm_tap_state_type      tap_state
);
  import pbm_pkg::*;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [4:0]  general_pin_select_reg;
  logic        port_cd_pin_select_reg;
  logic [2:0]  pb_en;
  logic [15:0] pc_en;
  logic [7:0]  pd_en;
  logic        aw_full;
  logic        w_full;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [15:0] wmask;
  logic        w_hit;
  logic [31:0] next_rdata;
  logic        r_hit;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;
  assign wmask         = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign w_hit = aw_addr inside {`PBM_ADDR_GPS, `PBM_ADDR_GPSCD, `PBM_ADDR_PB_EN,
                                 `PBM_ADDR_PC_EN, `PBM_ADDR_PD_EN};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PBM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= w_hit ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte lanes above bit 15 hold nothing, so only strobes 0 and 1 matter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_pin_select_reg <= `PBM_GPS_RST;
      port_cd_pin_select_reg <= `PBM_GPSCD_RST;
      pb_en                  <= `PBM_PB_EN_RST;
      pc_en                  <= `PBM_PC_EN_RST;
      pd_en                  <= `PBM_PD_EN_RST;
    end else if (do_write) begin
      case (aw_addr)
        `PBM_ADDR_GPS: general_pin_select_reg <= (general_pin_select_reg & ~wmask[4:0])
                                                 | (w_data[4:0] & wmask[4:0]);
        `PBM_ADDR_GPSCD: port_cd_pin_select_reg <= w_strb[0] ? w_data[0]
                                                             : port_cd_pin_select_reg;
        `PBM_ADDR_PB_EN: pb_en <= (pb_en & ~wmask[2:0]) | (w_data[2:0] & wmask[2:0]);
        `PBM_ADDR_PC_EN: pc_en <= (pc_en & ~wmask) | (w_data[15:0] & wmask);
        `PBM_ADDR_PD_EN: pd_en <= (pd_en & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0]);
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    r_hit      = 1'b1;
    case (s_axi_araddr)
      `PBM_ADDR_GPS:   next_rdata[4:0]  = general_pin_select_reg;
      `PBM_ADDR_GPSCD: next_rdata[0]    = port_cd_pin_select_reg;
      `PBM_ADDR_PB_EN: next_rdata[2:0]  = pb_en;
      `PBM_ADDR_PC_EN: next_rdata[15:0] = pc_en;
      `PBM_ADDR_PD_EN: next_rdata[7:0]  = pd_en;
      `PBM_ADDR_TAP:   next_rdata[3:0]  = tap_state;
      default:         r_hit            = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PBM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= r_hit ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin input filter
  // ----------------------------------------------------------------
  // A bit changes only once the second and third stages agree
  // Stages start high like the pulled-up pins, so leaving reset makes no false TCK rise
  logic [NPIN-1:0] sync_a;
  logic [NPIN-1:0] sync_b;
  logic [NPIN-1:0] sync_c;
  logic [NPIN-1:0] pin_f;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '1;
      sync_b <= '1;
      sync_c <= '1;
      pin_f  <= '1;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      pin_f  <= (sync_b & sync_c) | (pin_f & (sync_b ^ sync_c));
    end
  end

  // ----------------------------------------------------------------
  // Test-port state machine
  // ----------------------------------------------------------------
  localparam int TDI = `PBM_PD + 0;
  localparam int TDO = `PBM_PD + 1;
  localparam int TCK = `PBM_PD + 2;
  localparam int TMS = `PBM_PD + 3;
  logic              trst_n;
  logic              tck_q;
  logic              tck_rise;
  logic              tms;
  logic [2:0]        tms_cnt;
  pbm_tap_state_type next_tap_state;

  assign trst_n   = 1'b1;
  assign tms      = pin_f[TMS];
  // The TCK pin handed to GPIO (pd_en[2] low) stops the state machine where it is
  assign tck_rise = pin_f[TCK] && !tck_q && pd_en[2];

  always_comb begin
    case (tap_state)
      PBM_TLR:  next_tap_state = tms ? PBM_TLR  : PBM_RTI;
      PBM_RTI:  next_tap_state = tms ? PBM_SDRS : PBM_RTI;
      PBM_SDRS: next_tap_state = tms ? PBM_SIRS : PBM_CDR;
      PBM_CDR:  next_tap_state = tms ? PBM_E1DR : PBM_SDR;
      PBM_SDR:  next_tap_state = tms ? PBM_E1DR : PBM_SDR;
      PBM_E1DR: next_tap_state = tms ? PBM_UDR  : PBM_PDR;
      PBM_PDR:  next_tap_state = tms ? PBM_E2DR : PBM_PDR;
      PBM_E2DR: next_tap_state = tms ? PBM_UDR  : PBM_SDR;
      PBM_UDR:  next_tap_state = tms ? PBM_SDRS : PBM_RTI;
      PBM_SIRS: next_tap_state = tms ? PBM_TLR  : PBM_CIR;
      PBM_CIR:  next_tap_state = tms ? PBM_E1IR : PBM_SIR;
      PBM_SIR:  next_tap_state = tms ? PBM_E1IR : PBM_SIR;
      PBM_E1IR: next_tap_state = tms ? PBM_UIR  : PBM_PIR;
      PBM_PIR:  next_tap_state = tms ? PBM_E2IR : PBM_PIR;
      PBM_E2IR: next_tap_state = tms ? PBM_UIR  : PBM_SIR;
      PBM_UIR:  next_tap_state = tms ? PBM_SDRS : PBM_RTI;
      default:  next_tap_state = PBM_TLR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !trst_n) begin
      tap_state    <= PBM_TLR;
      tms_cnt      <= 3'h0;
      tck_q        <= 1'b1;
      tap_tck_rise <= 1'b0;
      tap_tdi      <= 1'b0;
    end else begin
      tck_q        <= pin_f[TCK];
      tap_tck_rise <= tck_rise;
      if (tck_rise) begin
        tap_tdi <= pin_f[TDI];
        tms_cnt <= !tms ? 3'h0 : (tms_cnt == `PBM_TMS_RESET) ? tms_cnt : tms_cnt + 3'h1;
        // The count guards the soft reset even if the walk is ever altered
        tap_state <= (tms && tms_cnt >= `PBM_TMS_RESET - 3'h1) ? PBM_TLR
                                                              : next_tap_state;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------
  logic [NPIN-1:0] en;
  logic [NPIN-1:0] next_out;
  logic [NPIN-1:0] next_drive;
  logic            shifting;

  assign en       = {pd_en, pc_en, pb_en};
  assign shifting = tap_state == PBM_SDR || tap_state == PBM_SIR;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_comb begin
        next_out[gi]   = gpio_out[gi];
        next_drive[gi] = gpio_oe[gi];
        if (en[gi]) begin
          next_out[gi]   = 1'b0;
          next_drive[gi] = 1'b0;
          if (gi == `PBM_PB) begin
            next_drive[gi] = 1'b1;
            next_out[gi]   = general_pin_select_reg[`PBM_GPS_B11] ? comparator_b_output
                                                                 : timer_b_channel_1;
          end else if (gi == `PBM_PB + 1) begin
            next_drive[gi] = 1'b1;
            next_out[gi]   = can_transmit_pin;
          end else if (gi == `PBM_PC + 8) begin
            next_drive[gi] = general_pin_select_reg[`PBM_GPS_C8];
            next_out[gi]   = serial2_transmit;
          end else if (gi == TDO) begin
            next_drive[gi] = shifting;
            next_out[gi]   = scan_tdo;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
      gpio_in  <= '0;
    end else begin
      pin_out  <= next_out;
      pin_oe_n <= ~next_drive;
      gpio_in  <= pin_f;
    end
  end

  // Analog connections follow the selects; the pin driver is off meanwhile
  logic [4:0] gps;
  assign gps = general_pin_select_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_connect          <= 16'h0000;
      comparator_a_input_3 <= 1'b0;
      comparator_b_input_3 <= 1'b0;
      serial2_receive      <= 1'b1;
      can_receive_pin      <= 1'b1;
      crystal_output       <= 1'b0;
      external_clock_input <= 1'b0;
      analog_out_0         <= 1'b0;
      analog_out_1         <= 1'b0;
    end else begin
      adc_connect <= pc_en & ~({3'h0, gps[`PBM_GPS_C12], 3'h0, gps[`PBM_GPS_C8], 3'h0,
                               gps[`PBM_GPS_C4], 3'h0, gps[`PBM_GPS_C0]});
      comparator_a_input_3 <= pc_en[0] && gps[`PBM_GPS_C0];
      comparator_b_input_3 <= pc_en[4] && gps[`PBM_GPS_C4];
      // Idle-high so a deselected receiver sees no start bit
      serial2_receive <= (pc_en[12] && gps[`PBM_GPS_C12]) ? pin_f[`PBM_PC + 12] : 1'b1;
      can_receive_pin <= pb_en[2] ? pin_f[`PBM_PB + 2] : 1'b1;
      crystal_output  <= pd_en[5] && !port_cd_pin_select_reg;
      external_clock_input <= pd_en[5] && port_cd_pin_select_reg && pin_f[`PBM_PD + 5];
      analog_out_0 <= pd_en[6];
      analog_out_1 <= pd_en[7];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_b11_mux;
    @(posedge aclk) disable iff (!aresetn)
    en[0] |=> !pin_oe_n[0] && pin_out[0] == ($past(gps[0]) ? $past(comparator_b_output)
                                                           : $past(timer_b_channel_1));
  endproperty
  a_b11_mux: assert property (p_b11_mux) else $error("B11 alternate wrong");

  property p_c0_sel;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> comparator_a_input_3 != (adc_connect[0] || !$past(pc_en[0]));
  endproperty
  a_c0_sel: assert property (p_c0_sel) else $error("C0 route wrong");

  property p_c4_sel;
    @(posedge aclk) disable iff (!aresetn)
    pc_en[4] |=> comparator_b_input_3 == !adc_connect[4];
  endproperty
  a_c4_sel: assert property (p_c4_sel) else $error("C4 route wrong");

  property p_c8_tx;
    @(posedge aclk) disable iff (!aresetn)
    en[11] && gps[3] |=> !pin_oe_n[11] && pin_out[11] == $past(serial2_transmit);
  endproperty
  a_c8_tx: assert property (p_c8_tx) else $error("C8 transmit wrong");

  property p_c12_rx;
    @(posedge aclk) disable iff (!aresetn)
    !(pc_en[12] && gps[4]) |=> serial2_receive;
  endproperty
  a_c12_rx: assert property (p_c12_rx) else $error("C12 receive leaks");

  property p_d5_sel;
    @(posedge aclk) disable iff (!aresetn)
    pd_en[5] |=> pin_oe_n[24] && crystal_output == !$past(port_cd_pin_select_reg)
                 && !(crystal_output && external_clock_input);
  endproperty
  a_d5_sel: assert property (p_d5_sel) else $error("D5 route wrong");

  property p_por_tap;
    @(posedge aclk) !aresetn |=> tap_state == PBM_TLR;
  endproperty
  a_por_tap: assert property (p_por_tap) else $error("TAP not reset");

  property p_soft_reset;
    @(posedge aclk) disable iff (!aresetn)
    tck_rise && tms && tms_cnt == 3'h4 |=> tap_state == PBM_TLR;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("TMS reset missed");

  property p_defaults;
    @(posedge aclk) !aresetn |=> en == {8'h0F, 16'h0000, 3'h0} && pin_oe_n[2:0] == 3'h7;
  endproperty
  a_defaults: assert property (p_defaults) else $error("Reset default wrong");

  property p_b13_in;
    @(posedge aclk) disable iff (!aresetn)
    en[2] |=> pin_oe_n[2];
  endproperty
  a_b13_in: assert property (p_b13_in) else $error("B13 driven");

  c_write: cover property (@(posedge aclk) do_write && w_hit);
  c_soft:  cover property (@(posedge aclk) tck_rise && tms && tms_cnt == 3'h4);
  c_tx:    cover property (@(posedge aclk) en[11] && gps[3]);
  c_shift: cover property (@(posedge aclk) shifting && en[TDO]);

endmodule // pbm_pin_mux

// ==== design/pbm_map.svh ====
// Register offsets, field positions and reset values of the pin mux block.
// Included by the pin mux module; holds definitions only.
`ifndef PBM_MAP_SVH
`define PBM_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PBM_ADDR_GPS    32'h0000_0000
`define PBM_ADDR_GPSCD  32'h0000_0004
`define PBM_ADDR_PB_EN  32'h0000_0008
`define PBM_ADDR_PC_EN  32'h0000_000C
`define PBM_ADDR_PD_EN  32'h0000_0010
`define PBM_ADDR_TAP    32'h0000_0014

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PBM_GPS_B11     0
`define PBM_GPS_C0      1
`define PBM_GPS_C4      2
`define PBM_GPS_C8      3
`define PBM_GPS_C12     4
`define PBM_GPSCD_D5    0
`define PBM_GPS_RST     5'h00
`define PBM_GPSCD_RST   1'h0
`define PBM_PB_EN_RST   3'h0
`define PBM_PC_EN_RST   16'h0000
`define PBM_PD_EN_RST   8'h0F

// Pin vector positions: port B 11..13, port C 0..15, port D 0..7
`define PBM_PB          0
`define PBM_PC          3
`define PBM_PD          19
`define PBM_TMS_RESET   3'h5
`define PBM_RESP_OKAY   2'h0
`define PBM_RESP_SLVERR 2'h2

`endif

// ==== design/pbm_pkg.sv ====
// Types shared by the pin mux block and its bench.
// Assumes nothing of its surroundings.
package pbm_pkg;

  typedef enum logic [3:0] {
    PBM_TLR  = 4'h0, PBM_RTI  = 4'h1, PBM_SDRS = 4'h2, PBM_CDR  = 4'h3,
    PBM_SDR  = 4'h4, PBM_E1DR = 4'h5, PBM_PDR  = 4'h6, PBM_E2DR = 4'h7,
    PBM_UDR  = 4'h8, PBM_SIRS = 4'h9, PBM_CIR  = 4'hA, PBM_SIR  = 4'hB,
    PBM_E1IR = 4'hC, PBM_PIR  = 4'hD, PBM_E2IR = 4'hE, PBM_UIR  = 4'hF
  } pbm_tap_state_type;

endpackage

// ==== dv/pbm_board_model.sv ====
// Board model around the pin mux: resolves each package pin from all drivers.
// Assumes the bench drives drv_en/drv_val in the place of external parts.
`timescale 1ns/10ps

module pbm_board_model #(
  parameter int NPIN = 27
) (
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe_n,
  input  wire logic [NPIN-1:0] drv_en,
  input  wire logic [NPIN-1:0] drv_val,
  output logic      [NPIN-1:0] pin_in
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Undriven pins float up: the board fits pull-ups, and there is no test-reset line at all
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (drv_en[i]) begin
        pin_in[i] = drv_val[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule // pbm_board_model

// ==== dv/pbm_pin_mux_test.sv ====
// Self-checking bench for the pin mux: register bus, routing and test-port walk.
// Assumes the board model of this folder and the design's register map header.
`timescale 1ns/10ps
`include "pbm_map.svh"

module pbm_pin_mux_test;
  import pbm_pkg::*;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs, bs;
  logic [26:0]       pin_in, pin_out, pin_oe_n, gpio_out, gpio_oe, gpio_in, drv_en, drv_val;
  logic              timer_b_channel_1, comparator_b_output, can_transmit_pin, can_receive_pin;
  logic              serial2_transmit, serial2_receive, comparator_a_input_3, comparator_b_input_3;
  logic              crystal_output, external_clock_input, analog_out_0, analog_out_1;
  logic              scan_tdo, tap_tdi, tap_tck_rise;
  logic [15:0]       adc_connect;
  logic [4:0]        g;
  pbm_tap_state_type tap_state;
  int                err_total, checks, rises;
  pbm_tap_state_type walk[5] = '{PBM_E1DR, PBM_UDR, PBM_SDRS, PBM_SIRS, PBM_TLR};

  pbm_pin_mux #(.NPIN(27)) dut (.*);
  pbm_board_model #(.NPIN(27)) board (.*);

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // Counts internal TCK rises, looked at mid-cycle where the pulse is settled
  always @(negedge aclk) begin
    if (tap_tck_rise === 1'b1) rises++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Ready is combinational, so it is looked at mid-cycle and the handshake lands on the next rise
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready);
      w_ok = w_ok || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (!s_axi_bvalid);
    bs = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Each level is held well over the three-flop pin filter
  task automatic tck_pulse(input logic tms);
    logic tdi;
    tdi = 1'($urandom);
    drv_val[22] <= tms;
    drv_val[21] <= 1'b0;
    drv_val[19] <= tdi;
    wait_clk(8);
    drv_val[21] <= 1'b1;
    wait_clk(8);
    chk("tap_tdi", 32'(tap_tdi), 32'(tdi));
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rd = $urandom(6723);
    err_total = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'h0;
    gpio_out = 27'($urandom);
    gpio_oe = '1;
    drv_en = '0;
    drv_val = '0;
    {timer_b_channel_1, comparator_b_output, can_transmit_pin, serial2_transmit} = 4'h0;
    scan_tdo = 1'b0;
    wait_clk(10);
    aresetn <= 1'b1;
    wait_clk(2);
    chk("tap_state", 32'(tap_state), 32'(PBM_TLR));
    chk("pin_oe_n", 32'(pin_oe_n), 32'h0078_0000);
    chk("pin_out", 32'(pin_out[18:0]), 32'(gpio_out[18:0]));
    for (int i = 0; i < 6; i++) begin
      axi_read(32'(4 * i), rd, rs);
      chk("reset value", rd, (i == 4) ? 32'h0000_000F : 32'h0);
    end
    axi_read(32'h0000_0018, rd, rs);
    chk("unmapped rresp", 32'(rs), 32'(`PBM_RESP_SLVERR));
    chk("unmapped rdata", rd, 32'h0);
    axi_write(`PBM_ADDR_TAP, 32'h0000_000F);
    chk("read-only bresp", 32'(bs), 32'(`PBM_RESP_SLVERR));
    axi_write(`PBM_ADDR_PB_EN, 32'h0000_0007);
    chk("bresp", 32'(bs), 32'(`PBM_RESP_OKAY));
    axi_write(`PBM_ADDR_PC_EN, 32'h0000_FFFF);
    axi_write(`PBM_ADDR_PD_EN, 32'h0000_00EF);
    for (int i = 0; i < 10; i++) begin
      g = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      timer_b_channel_1 <= 1'($urandom);
      comparator_b_output <= 1'($urandom);
      can_transmit_pin <= 1'($urandom);
      serial2_transmit <= 1'($urandom);
      gpio_out <= 27'($urandom);
      axi_write(`PBM_ADDR_GPS, 32'(g));
      wait_clk(2);
      chk("b11 out", 32'(pin_out[0]), 32'(g[0] ? comparator_b_output : timer_b_channel_1));
      chk("b11 oe_n", 32'(pin_oe_n[0]), 32'h0);
      chk("c0 route", 32'({adc_connect[0], comparator_a_input_3}), 32'({!g[1], g[1]}));
      chk("c4 route", 32'({adc_connect[4], comparator_b_input_3}), 32'({!g[2], g[2]}));
      chk("c8 route", 32'({adc_connect[8], pin_oe_n[11]}), 32'({!g[3], !g[3]}));
      if (g[3]) chk("c8 out", 32'(pin_out[11]), 32'(serial2_transmit));
      chk("b12 out", 32'({pin_out[1], pin_oe_n[1]}), 32'({can_transmit_pin, 1'b0}));
      chk("dac", 32'({analog_out_0, analog_out_1, pin_oe_n[25]}), 32'h7);
      chk("d4 gpio", 32'({pin_out[23], pin_oe_n[23]}), 32'({gpio_out[23], 1'b0}));
    end
    axi_write(`PBM_ADDR_GPS, 32'h0000_0010);
    drv_en[15] <= 1'b1;
    drv_en[2] <= 1'b1;
    drv_en[24] <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      drv_val[15] <= v[0];
      drv_val[2] <= v[0];
      wait_clk(8);
      chk("serial rx", 32'(serial2_receive), 32'(v));
      chk("can rx", 32'(can_receive_pin), 32'(v));
      chk("gpio in", 32'(gpio_in[15]), 32'(v));
    end
    axi_write(`PBM_ADDR_GPS, 32'h0);
    wait_clk(2);
    chk("c12 adc", 32'({serial2_receive, adc_connect[12]}), 32'h3);
    chk("crystal", 32'(crystal_output), 32'h1);
    axi_write(`PBM_ADDR_GPSCD, 32'h0000_0001);
    for (int v = 0; v < 2; v++) begin
      drv_val[24] <= v[0];
      wait_clk(8);
      chk("clock in", 32'({crystal_output, external_clock_input}), 32'(v));
    end
    // Tester side of the test port: TMS and TCK come from the board
    drv_en[22:19] <= 4'hD;
    drv_val[22:21] <= 2'b10;
    scan_tdo <= 1'b1;
    wait_clk(8);
    tck_pulse(1'b0);
    tck_pulse(1'b1);
    tck_pulse(1'b0);
    tck_pulse(1'b0);
    chk("tap shift", 32'(tap_state), 32'(PBM_SDR));
    wait_clk(50);
    chk("tap idle", 32'(tap_state), 32'(PBM_SDR));
    chk("tdo pin", 32'({pin_oe_n[20], pin_out[20]}), 32'h1);
    axi_read(`PBM_ADDR_TAP, rd, rs);
    chk("tap status", rd, 32'(PBM_SDR));
    for (int i = 0; i < 5; i++) begin
      tck_pulse(1'b1);
      chk("tms walk", 32'(tap_state), 32'(walk[i]));
    end
    tck_pulse(1'b0);
    chk("tap idle", 32'(tap_state), 32'(PBM_RTI));
    aresetn <= 1'b0;
    wait_clk(10);
    aresetn <= 1'b1;
    wait_clk(2);
    chk("tap por", 32'(tap_state), 32'(PBM_TLR));
    axi_read(`PBM_ADDR_GPSCD, rd, rs);
    chk("select after reset", rd, 32'h0);
    chk("tck rises", 32'(rises), 32'h0000_000A);
    end_of_test();
  end
endmodule // pbm_pin_mux_test
